// ### jtag_tap_pkg.sv
// constants shared by the tap controller and its data fifo
// assumes one system clock that oversamples the test clock pins
package jtag_tap_pkg;

	// ************************************************
	// instruction register
	// ************************************************
	localparam int unsigned IR_W       = 4;           // instruction width
	localparam logic [3:0]  IR_CAPTURE = 4'h1;        // pattern loaded in capture-ir
	localparam logic [3:0]  INS_BYPASS = 4'hF;        // one-bit bypass path
	localparam logic [3:0]  INS_DATA   = 4'h2;        // user data register path
	localparam logic [3:0]  INS_RUN    = 4'h3;        // acts while resting in run-test/idle
	localparam logic [3:0]  IR_RESET   = INS_BYPASS;  // instruction after test-logic-reset

	// ************************************************
	// timing and counts
	// ************************************************
	localparam logic [2:0]  TLR_ONES   = 3'h5;        // tms-high periods forcing reset
	localparam int unsigned FIFO_DEPTH = 8;           // words buffered after update-dr

	// ************************************************
	// tap states, one-hot
	// ************************************************
	typedef enum logic [15:0] {
		S_TLR   = 16'h0001,
		S_RTI   = 16'h0002,
		S_SELDR = 16'h0004,
		S_CAPDR = 16'h0008,
		S_SDR   = 16'h0010,
		S_EX1DR = 16'h0020,
		S_PAUDR = 16'h0040,
		S_EX2DR = 16'h0080,
		S_UPDDR = 16'h0100,
		S_SELIR = 16'h0200,
		S_CAPIR = 16'h0400,
		S_SIR   = 16'h0800,
		S_EX1IR = 16'h1000,
		S_PAUIR = 16'h2000,
		S_EX2IR = 16'h4000,
		S_UPDIR = 16'h8000
	} tap_state_t;

endpackage : jtag_tap_pkg

// ### jtag_fifo.sv
// small flip-flop fifo with valid/ready on both sides
// assumes writer and reader share clk_i; depth is a power of two
`timescale 1ns/1ns
module jtag_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// filling side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// draining side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];  // storage words
	logic [AW-1:0]    wr_ptr;       // next slot to write
	logic [AW-1:0]    rd_ptr;       // next slot to read
	logic [AW:0]      count;        // words held
	logic             push;         // accepted write
	logic             pop;          // accepted read

	// honest flags straight from the count
	assign in_ready_o  = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o  = mem[rd_ptr];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// storage write, no reset needed on data
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	// pointers and occupancy
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule : jtag_fifo

// ### jtag_tap.sv
// tap controller with instruction register, bypass and one user data register
// assumes tck/tms/tdi arrive asynchronously and tck is far slower than clk_i
`timescale 1ns/1ns

// Behaviour
// (R1) sixteen states on tms, reset enters test-logic-reset
// (R2) all shift paths move lsb first
// (R3) four-bit ir, captures 0x01 in capture-ir before shifting
// (R4) from idle tms 1,0,0 reaches shift-dr
// (R5) shift-dr takes one tdi bit per rise
// (R6) msb shifts on the edge leaving shift-dr
// (R7) tdo carries values captured in capture-dr
// (R8) tms 1,1,0 after shifting returns to idle
// (R9) latched dr output changes only in update-dr
// (R10) exit/pause ir states only navigate
// (R11) update-ir may go straight to select-dr
// (R12) some instructions act in run-test/idle
// (R13) five tms-high periods force test-logic-reset
// (R14) tdo changes on falling tck, driven only shifting
module jtag_tap
	import jtag_tap_pkg::*;
#(
	parameter int unsigned DR_W = 8  // user data register width
) (
	// clock and reset
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	// test access pins
	input  wire logic            tck_i,
	input  wire logic            tms_i,
	input  wire logic            tdi_i,
	output logic                 tdo_o,
	output logic                 tdo_oe_n_o,
	// user data register
	input  wire logic [DR_W-1:0] dr_cap_i,
	output logic      [DR_W-1:0] dr_out_o,
	output logic                 dr_valid_o,
	input  wire logic            dr_ready_i,
	output logic      [DR_W-1:0] dr_data_o,
	output logic                 dr_drop_o,
	// status
	output logic      [IR_W-1:0] ir_o,
	output logic                 run_pulse_o
);
	// ************************************************
	// pin synchronisers and edge detect
	// ************************************************
	logic [1:0] tck_sync;   // [0] only feeds [1]
	logic [1:0] tms_sync;
	logic [1:0] tdi_sync;
	logic       tck_last;   // previous synced tck
	logic       tck_rise;   // one-cycle enable
	logic       tck_fall;   // one-cycle enable
	logic       tms;
	logic       tdi;

	// two flops per pin before any logic looks at it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tck_sync <= 2'h0;
			tms_sync <= 2'h3;
			tdi_sync <= 2'h3;
			tck_last <= 1'b0;
		end else begin
			tck_sync <= {tck_sync[0], tck_i};
			tms_sync <= {tms_sync[0], tms_i};
			tdi_sync <= {tdi_sync[0], tdi_i};
			tck_last <= tck_sync[1];
		end
	end

	// all pins share the same delay, so tms/tdi stay aligned to the edge
	assign tck_rise = tck_sync[1] && !tck_last;
	assign tck_fall = !tck_sync[1] && tck_last;
	assign tms      = tms_sync[1];
	assign tdi      = tdi_sync[1];

	// ************************************************
	// tap state machine
	// ************************************************
	tap_state_t state;       // present tap state
	tap_state_t next_state;  // state after next rise

	function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
		unique case (s)
			S_TLR:   tap_next = m ? S_TLR   : S_RTI;
			S_RTI:   tap_next = m ? S_SELDR : S_RTI;
			S_SELDR: tap_next = m ? S_SELIR : S_CAPDR;
			S_CAPDR: tap_next = m ? S_EX1DR : S_SDR;
			S_SDR:   tap_next = m ? S_EX1DR : S_SDR;
			S_EX1DR: tap_next = m ? S_UPDDR : S_PAUDR;
			S_PAUDR: tap_next = m ? S_EX2DR : S_PAUDR;
			S_EX2DR: tap_next = m ? S_UPDDR : S_SDR;
			S_UPDDR: tap_next = m ? S_SELDR : S_RTI;
			S_SELIR: tap_next = m ? S_TLR   : S_CAPIR;
			S_CAPIR: tap_next = m ? S_EX1IR : S_SIR;
			S_SIR:   tap_next = m ? S_EX1IR : S_SIR;
			S_EX1IR: tap_next = m ? S_UPDIR : S_PAUIR;
			S_PAUIR: tap_next = m ? S_EX2IR : S_PAUIR;
			S_EX2IR: tap_next = m ? S_UPDIR : S_SIR;
			S_UPDIR: tap_next = m ? S_SELDR : S_RTI;
			default: tap_next = S_TLR;
		endcase
	endfunction : tap_next
	assign next_state = tap_next(state, tms);

	// advance only on a test-clock rise
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= S_TLR; // R1
		end else if (tck_rise) begin
			state <= next_state; // R1 R4 R8 R11 R13
		end
	end

	// ************************************************
	// instruction register
	// ************************************************
	logic [IR_W-1:0] ir_sr;  // instruction shift stage
	logic [IR_W-1:0] ir;     // active instruction

	// capture, shift lsb first; exit/pause states leave it alone
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ir_sr <= IR_CAPTURE;
		end else if (tck_rise) begin // R10
			if (state == S_CAPIR) begin
				ir_sr <= IR_CAPTURE; // R3
			end else if (state == S_SIR) begin
				ir_sr <= {tdi, ir_sr[IR_W-1:1]}; // R2 R3
			end
		end
	end

	// latch instruction in update-ir, default on reset state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ir <= IR_RESET;
		end else if (tck_rise) begin
			if (state == S_TLR) begin
				ir <= IR_RESET;
			end else if (state == S_UPDIR) begin
				ir <= ir_sr;
			end
		end
	end
	assign ir_o = ir;

	// ************************************************
	// data registers
	// ************************************************
	logic            sel_user;  // user dr chosen
	logic [DR_W-1:0] dr_sr;     // user dr shift stage
	logic            byp_sr;    // bypass bit
	logic            push_ok;   // fifo accepts the update
	assign sel_user = (ir == INS_DATA);

	// capture parallel inputs, then shift lsb first; last bit on exit edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dr_sr  <= '0;
			byp_sr <= 1'b0;
		end else if (tck_rise) begin
			if (state == S_CAPDR) begin
				dr_sr  <= dr_cap_i; // R7
				byp_sr <= 1'b0;
			end else if (state == S_SDR) begin
				dr_sr  <= {tdi, dr_sr[DR_W-1:1]}; // R2 R5 R6
				byp_sr <= tdi;
			end
		end
	end

	// latched output moves only on the update-dr rise
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dr_out_o <= '0;
		end else if (tck_rise && state == S_UPDDR && sel_user) begin
			dr_out_o <= dr_sr; // R9
		end
	end

	// the tester cannot be stalled, so a full fifo drops the word and flags it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dr_drop_o <= 1'b0;
		end else if (tck_rise && state == S_UPDDR && sel_user) begin
			dr_drop_o <= !push_ok;
		end
	end

	jtag_fifo #(
		.WIDTH (DR_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (tck_rise && state == S_UPDDR && sel_user),
		.in_ready_o  (push_ok),
		.in_data_i   (dr_sr),
		.out_valid_o (dr_valid_o),
		.out_ready_i (dr_ready_i),
		.out_data_o  (dr_data_o)
	);

	// ************************************************
	// run-test/idle action
	// ************************************************
	// one pulse per tck rise while idling under the action instruction
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			run_pulse_o <= 1'b0;
		end else begin
			run_pulse_o <= tck_rise && state == S_RTI && ir == INS_RUN; // R12
		end
	end

	// ************************************************
	// test data out
	// ************************************************
	// update on falling tck so the tester samples a settled bit on the rise
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tdo_o      <= 1'b0;
			tdo_oe_n_o <= 1'b1;
		end else if (tck_fall) begin
			tdo_oe_n_o <= !(state == S_SIR || state == S_SDR); // R14
			if (state == S_SIR) begin
				tdo_o <= ir_sr[0]; // R3
			end else if (state == S_SDR) begin
				tdo_o <= sel_user ? dr_sr[0] : byp_sr; // R7
			end
		end
	end

	// ************************************************
	// checks
	// ************************************************
	// every check below runs on clk_i and rests while reset is held
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [2:0] ones_cnt;  // consecutive tms-high rises, saturating
	// saturating count, so a long run of ones cannot wrap back below five
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ones_cnt <= 3'h0;
		end else if (tck_rise) begin
			ones_cnt <= !tms ? 3'h0 : (ones_cnt == TLR_ONES) ? TLR_ONES : ones_cnt + 3'h1;
		end
	end

	property p_start_tlr;
		$fell(rst_i) |-> state == S_TLR;
	endproperty
	a_start_tlr: assert property (p_start_tlr) else $error("not in reset state after reset"); // R1
	property p_shift_lsb;
		(tck_rise && state == S_SDR) |=> dr_sr[DR_W-1] == $past(tdi) && dr_sr[DR_W-2:0] == $past(dr_sr[DR_W-1:1]);
	endproperty
	a_shift_lsb: assert property (p_shift_lsb) else $error("dr shift order wrong"); // R2
	property p_ir_capture;
		(tck_rise && state == S_CAPIR) |=> ir_sr == IR_CAPTURE && state == tap_state_t'($past(next_state));
	endproperty
	a_ir_capture: assert property (p_ir_capture) else $error("ir capture value wrong"); // R3
	property p_dr_entry;
		(tck_rise && state == S_SELDR && !tms) |=> state == S_CAPDR;
	endproperty
	a_dr_entry: assert property (p_dr_entry) else $error("select-dr did not capture"); // R4
	property p_dr_exit;
		(tck_rise && state == S_SDR && tms) |=> state == S_EX1DR && dr_sr[DR_W-1] == $past(tdi);
	endproperty
	a_dr_exit: assert property (p_dr_exit) else $error("exit edge lost msb"); // R6
	property p_tdo_fall;
		!tck_fall |=> $stable(tdo_o) && $stable(tdo_oe_n_o);
	endproperty
	a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off falling edge"); // R14
	property p_upd_only;
		!$stable(dr_out_o) |-> $past(state) == S_UPDDR && $past(tck_rise);
	endproperty
	a_upd_only: assert property (p_upd_only) else $error("dr output moved outside update"); // R9
	property p_ir_nav;
		(state == S_EX1IR || state == S_PAUIR || state == S_EX2IR) |=> $stable(ir_sr) && $stable(ir);
	endproperty
	a_ir_nav: assert property (p_ir_nav) else $error("ir changed in navigation state"); // R10
	property p_upd_to_idle;
		(tck_rise && state == S_UPDDR && !tms) |=> state == S_RTI;
	endproperty
	a_upd_to_idle: assert property (p_upd_to_idle) else $error("update-dr did not return to idle"); // R8
	property p_ir_to_dr;
		(tck_rise && state == S_UPDIR && tms) |=> state == S_SELDR;
	endproperty
	a_ir_to_dr: assert property (p_ir_to_dr) else $error("update-ir did not reach select-dr"); // R11
	property p_run_act;
		(tck_rise && state == S_RTI && ir == INS_RUN) |=> run_pulse_o ##1 !run_pulse_o;
	endproperty
	a_run_act: assert property (p_run_act) else $error("idle action pulse missing"); // R12
	property p_five_ones;
		ones_cnt == TLR_ONES |-> state == S_TLR;
	endproperty
	a_five_ones: assert property (p_five_ones) else $error("five tms highs did not reset"); // R13
endmodule : jtag_tap

// ### jtag_tester.sv
// tester model: drives test clock, mode and data pins, reads tdo
// assumes the caller steps it from clk_i; tck rests low between steps
`timescale 1ns/1ns
module jtag_tester (
	// system clock
	input  wire logic clk_i,
	// test access pins
	output logic      tck_o,
	output logic      tms_o,
	output logic      tdi_o,
	input  wire logic tdo_i
);
	// ************************************************
	// pin stepping
	// ************************************************
	// link clock stands still low outside frames
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b0;
	end

	// one tck period of 8 clk: 4 low, 4 high
	task automatic step(input logic ms, input logic di, output logic do_);
		@(posedge clk_i);
		tms_o <= ms;
		tdi_o <= di;
		repeat (3) @(posedge clk_i);
		tck_o <= 1'b1;
		#1 do_ = tdo_i;
		repeat (4) @(posedge clk_i);
		tck_o <= 1'b0;
		tdi_o <= ~di; // no stale data left on a released line
	endtask : step
endmodule : jtag_tester

// ### testbench.sv
// self-checking bench for the tap controller and its update fifo
// assumes a 25 MHz clk, tck at 320 ns stepped by the tester model
`timescale 1ns/1ns
module testbench
	import jtag_tap_pkg::*;
;
	// ************************************************
	// signals
	// ************************************************
	logic       clk = 1'b0, rst = 1'b1, dr_ready = 1'b0;  // clock, reset, consumer
	logic       tck, tms, tdi, tdo, tdo_oe_n;              // test pins
	logic       dr_valid, dr_drop, run_pulse;              // status
	logic [7:0] dr_cap = 8'h00, dr_out, dr_data;           // user register
	logic [3:0] ir;                                        // active instruction
	int         mismatches = 0, n_tests = 0, pulses = 0;   // counters

	// clock and idle-action pulse count
	always #20 clk = ~clk;
	always @(posedge clk) if (run_pulse === 1'b1) pulses <= pulses + 1;

	jtag_tap #(.DR_W(8)) uut (.clk_i(clk), .rst_i(rst), .tck_i(tck), .tms_i(tms),
		.tdi_i(tdi), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n), .dr_cap_i(dr_cap),
		.dr_out_o(dr_out), .dr_valid_o(dr_valid), .dr_ready_i(dr_ready),
		.dr_data_o(dr_data), .dr_drop_o(dr_drop), .ir_o(ir), .run_pulse_o(run_pulse));
	jtag_tester tst (.clk_i(clk), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));

	// ************************************************
	// shared tasks
	// ************************************************
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	// tms sequence, lsb first, tdi idle
	task automatic nav(input logic [7:0] seq, input int n);
		logic d;
		for (int i = 0; i < n; i++) tst.step(seq[i], 1'b0, d);
	endtask : nav

	// shift n bits, tms high on the last; oe_n ors the enable seen
	task automatic scan(input logic [7:0] din, input int n, output logic [7:0] dout, output logic oe_n);
		logic b;
		dout = 8'h00;
		oe_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			tst.step(i == n - 1, din[i], b);
			dout[i] = b;
			oe_n = oe_n | tdo_oe_n;
		end
	endtask : scan

	// full data scan from idle back to idle
	task automatic dr_scan(input logic [7:0] din, output logic [7:0] dout);
		logic oe;
		nav(8'h01, 3);
		scan(din, 8, dout, oe);
		nav(8'h01, 2);
	endtask : dr_scan

	// load an instruction from idle
	task automatic t_ir(input logic [3:0] ins);
		logic [7:0] o;
		logic       oe;
		nav(8'h03, 4);
		scan({4'h0, ins}, 4, o, oe);
		check("ir capture", {4'h0, IR_CAPTURE}, {4'h0, o[3:0]});
		nav(8'h01, 2);
		check("ir", {4'h0, ins}, {4'h0, ir});
	endtask : t_ir

	// ************************************************
	// scenarios
	// ************************************************
	task automatic t_reset;
		check("ir after reset", {4'h0, IR_RESET}, {4'h0, ir});
		check("tdo enable", 8'h01, {7'h00, tdo_oe_n});
		check("dr out", 8'h00, dr_out);
		check("fifo valid", 8'h00, {7'h00, dr_valid});
		nav(8'h00, 1);
	endtask : t_reset

	task automatic t_user;
		logic [7:0] o;
		logic       oe;
		t_ir(INS_DATA);
		@(posedge clk);
		dr_cap <= 8'hA5;
		nav(8'h01, 3);
		scan(8'h3C, 8, o, oe);
		check("dr capture", 8'hA5, o);
		check("tdo enable shifting", 8'h00, {7'h00, oe});
		check("dr out early", 8'h00, dr_out);
		nav(8'h01, 2);
		check("dr out", 8'h3C, dr_out);
		check("fifo drop clear", 8'h00, {7'h00, dr_drop});
		check("tdo enable idle", 8'h01, {7'h00, tdo_oe_n});
	endtask : t_user

	// fill with consumer stalled, overflow, then drain
	task automatic t_fifo;
		logic [7:0] o;
		int         k;
		for (k = 0; k < 7; k++) dr_scan(8'(8'h10 + k), o);
		dr_scan(8'hEE, o);
		check("fifo drop", 8'h01, {7'h00, dr_drop});
		@(posedge clk);
		dr_ready <= 1'b1;
		k = 0;
		repeat (40) begin
			@(negedge clk);
			if (dr_valid === 1'b1 && k < 8) begin
				check("fifo word", (k == 0) ? 8'h3C : 8'(8'h0F + k), dr_data);
				k++;
			end
		end
		check("fifo count", 8'h08, 8'(k));
		check("fifo empty", 8'h00, {7'h00, dr_valid});
		if (k < 8) wrap_up;
		@(posedge clk);
		dr_ready <= 1'b0;
	endtask : t_fifo

	// ir pauses, then straight from update-ir into a bypass scan
	task automatic t_bypass;
		logic [7:0] o;
		logic       oe;
		nav(8'h03, 4);
		scan({4'h0, INS_BYPASS}, 4, o, oe);
		nav(8'h04, 3);
		check("ir in pause", {4'h0, INS_DATA}, {4'h0, ir});
		check("tdo enable pause", 8'h01, {7'h00, tdo_oe_n});
		nav(8'h03, 4);
		check("ir bypass", {4'h0, INS_BYPASS}, {4'h0, ir});
		scan(8'h0D, 4, o, oe);
		check("bypass out", 8'h0A, {4'h0, o[3:0]});
		nav(8'h01, 2);
	endtask : t_bypass

	// idle action instruction, then forced reset from shift-dr
	task automatic t_run_tlr;
		int p0;
		t_ir(INS_RUN);
		p0 = pulses;
		nav(8'h00, 3);
		repeat (8) @(posedge clk);
		check("idle pulses", 8'h03, 8'(pulses - p0));
		nav(8'h01, 3);
		nav(8'h1F, 5);
		// ir reloads on a rise spent in test-logic-reset; tms 0 there proves five ones got there
		nav(8'h00, 1);
		check("ir after tms ones", {4'h0, IR_RESET}, {4'h0, ir});
		check("tdo enable reset", 8'h01, {7'h00, tdo_oe_n});
	endtask : t_run_tlr

	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		t_reset;
		t_user;
		t_fifo;
		t_bypass;
		t_run_tlr;
		wrap_up;
	end
endmodule : testbench
